/* verilog/bstp_consts.vh */
`ifndef BSTP_CONSTS_VH
`define BSTP_CONSTS_VH
// Instruction register width
`define BSTP_IR_LEN 3
// Boundary register default length (smallest variant)
`define BSTP_BSR_LEN 273
// Instruction codes, 3-bit
`define BSTP_OP_EXTEST 3'h0
`define BSTP_OP_SAMPLE 3'h1
`define BSTP_OP_BYPASS 3'h7
// Capture pattern for instruction register
`define BSTP_IR_CAPTURE 3'h1
// Controller state codes, one-hot
`define BSTP_ST_RESET 16'h0001
`define BSTP_ST_IDLE 16'h0002
`define BSTP_ST_SEL_DR 16'h0004
`define BSTP_ST_CAP_DR 16'h0008
`define BSTP_ST_SH_DR 16'h0010
`define BSTP_ST_EX1_DR 16'h0020
`define BSTP_ST_PA_DR 16'h0040
`define BSTP_ST_EX2_DR 16'h0080
`define BSTP_ST_UP_DR 16'h0100
`define BSTP_ST_SEL_IR 16'h0200
`define BSTP_ST_CAP_IR 16'h0400
`define BSTP_ST_SH_IR 16'h0800
`define BSTP_ST_EX1_IR 16'h1000
`define BSTP_ST_PA_IR 16'h2000
`define BSTP_ST_EX2_IR 16'h4000
`define BSTP_ST_UP_IR 16'h8000
`endif

/* verilog/bstp_port.v */
`timescale 1ns/10ps
// Function
// - Sample/preload captures pins, preloads pattern
// - Extest drives pattern, captures input pins
// - Bypass uses one-stage register TDI-TDO
// - Bypass leaves core logic untouched
// - Instruction register is three bits
// - Boundary register length per variant
// - Undriven test inputs read as high
// Shared lengths, codes and state codes, needed by the parameter defaults
`include "bstp_consts.vh"
module bstp_port #(
    parameter BSR_LEN = `BSTP_BSR_LEN,
    parameter NPIN = 91
) (
    input wire sys_clk,
    input wire resetn,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire tms_oe_n,
    input wire tdi_oe_n,
    input wire tck_oe_n,
    output reg tdo_o,
    output reg tdo_oe,
    input wire [NPIN-1:0] core_out,
    input wire [NPIN-1:0] core_oe,
    input wire [NPIN-1:0] pin_in,
    output wire [NPIN-1:0] pin_out,
    output wire [NPIN-1:0] pin_oe,
    output wire [NPIN-1:0] core_in
);
    // Controller states, one-hot
    // Reset and idle
    localparam ST_RESET = `BSTP_ST_RESET;
    localparam ST_IDLE = `BSTP_ST_IDLE;
    // Data register column
    localparam ST_SEL_DR = `BSTP_ST_SEL_DR;
    localparam ST_CAP_DR = `BSTP_ST_CAP_DR;
    localparam ST_SH_DR = `BSTP_ST_SH_DR;
    localparam ST_EX1_DR = `BSTP_ST_EX1_DR;
    localparam ST_PA_DR = `BSTP_ST_PA_DR;
    localparam ST_EX2_DR = `BSTP_ST_EX2_DR;
    localparam ST_UP_DR = `BSTP_ST_UP_DR;
    // Instruction register column
    localparam ST_SEL_IR = `BSTP_ST_SEL_IR;
    localparam ST_CAP_IR = `BSTP_ST_CAP_IR;
    localparam ST_SH_IR = `BSTP_ST_SH_IR;
    localparam ST_EX1_IR = `BSTP_ST_EX1_IR;
    localparam ST_PA_IR = `BSTP_ST_PA_IR;
    localparam ST_EX2_IR = `BSTP_ST_EX2_IR;
    localparam ST_UP_IR = `BSTP_ST_UP_IR;
    // Boundary cell layout: per pin input, output, enable
    localparam CELLS = 3 * NPIN;
    localparam BL = (BSR_LEN > CELLS) ? BSR_LEN : CELLS;

    // Two-stage synchronisers; stage one read only by stage two
    // Top three bits: pin releases, low three: pin levels
    reg [5:0] s1_q;
    reg [5:0] s2_q;
    reg tck_prev_q; // Edge detector history

    // Pull-up folded in after syncing, so release and level age together
    // released reads high
    wire tck_s = s2_q[5] | s2_q[2]; // Test clock, pull-up applied
    wire tms_s = s2_q[4] | s2_q[1]; // Mode select, pull-up applied
    wire tdi_s = s2_q[3] | s2_q[0]; // Serial data in, pull-up applied

    // Reset to the released level: no false rise after reset
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= {6{1'b1}};
            s2_q <= {6{1'b1}};
            tck_prev_q <= 1'b1;
        end else begin
            s1_q <= {tck_oe_n, tms_oe_n, tdi_oe_n, tck, tms, tdi};
            s2_q <= s1_q;
            tck_prev_q <= tck_s;
        end
    end
    wire rise = tck_s & ~tck_prev_q; // Test clock rising
    wire fall = ~tck_s & tck_prev_q; // Test clock falling

    // Pin levels for the capture cells, two stages like the test pins
    // The core path stays direct: flops there would disturb normal operation
    reg [NPIN-1:0] pin_s1_q; // Pin level, first stage
    reg [NPIN-1:0] pin_s2_q; // Pin level, second stage
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= {NPIN{1'b0}};
            pin_s2_q <= {NPIN{1'b0}};
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    reg [15:0] st_q; // Controller state, one-hot
    reg [15:0] st_d;
    always @* begin
        st_d = st_q;
        case (st_q)
            // Both columns share one shape
            ST_RESET: st_d = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = tms_s ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: st_d = tms_s ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_d = tms_s ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = tms_s ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: st_d = tms_s ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_d = tms_s ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: st_d = tms_s ? ST_SEL_DR : ST_IDLE;
            // Illegal code recovers to reset
            default: st_d = ST_RESET;
        endcase
    end

    reg [`BSTP_IR_LEN-1:0] irs_q; // Instruction shift stage
    reg [`BSTP_IR_LEN-1:0] ir_q; // Active instruction
    reg byp_q; // One-bit bypass stage
    reg [BL-1:0] bsr_q; // Boundary shift stage
    reg [BL-1:0] upd_q; // Boundary update latch

    wire is_ext = (ir_q == `BSTP_OP_EXTEST);
    wire is_smp = (ir_q == `BSTP_OP_SAMPLE);
    // Unknown codes act as bypass, as the standard asks
    wire use_bsr = is_ext | is_smp;

    // Pin snapshot: input cells, output cells, enable cells
    wire [BL-1:0] snap;
    genvar gi;
    generate
        for (gi = 0; gi < BL; gi = gi + 1) begin : g_snap
            if (gi < NPIN) begin : g_in
                assign snap[gi] = pin_s2_q[gi];
            end else if (gi < 2 * NPIN) begin : g_out
                assign snap[gi] = core_out[gi - NPIN];
            end else if (gi < CELLS) begin : g_oe
                assign snap[gi] = core_oe[gi - 2 * NPIN];
            end else begin : g_pad
                // Spare cells capture zero
                assign snap[gi] = 1'b0;
            end
        end
    endgenerate

    // Register updates on test clock rising edge
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_RESET;
            irs_q <= {`BSTP_IR_LEN{1'b0}};
            ir_q <= `BSTP_OP_BYPASS;
            byp_q <= 1'b0;
            bsr_q <= {BL{1'b0}};
            upd_q <= {BL{1'b0}};
        end else if (rise) begin
            st_q <= st_d;
            case (st_q)
                // Reset state selects bypass
                ST_RESET: ir_q <= `BSTP_OP_BYPASS;
                // Fixed pattern lets a tester check the path
                ST_CAP_IR: irs_q <= `BSTP_IR_CAPTURE;
                ST_SH_IR: irs_q <= {tdi_s, irs_q[`BSTP_IR_LEN-1:1]};
                ST_UP_IR: ir_q <= irs_q;
                ST_CAP_DR: begin
                    byp_q <= 1'b0;
                    if (use_bsr) begin
                        bsr_q <= snap;
                    end
                end
                ST_SH_DR: begin
                    byp_q <= tdi_s;
                    if (use_bsr) begin
                        bsr_q <= {tdi_s, bsr_q[BL-1:1]};
                    end
                end
                ST_UP_DR: begin
                    if (use_bsr) begin
                        upd_q <= bsr_q;
                    end
                end
                default: ;
            endcase
        end
    end

    // Output changes on test clock falling edge
    // Falling-edge launch gives the tester half a period of setup
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tdo_o <= 1'b1;
            tdo_oe <= 1'b0;
        end else if (fall) begin
            tdo_oe <= (st_q == ST_SH_DR) | (st_q == ST_SH_IR);
            if (st_q == ST_SH_IR) begin
                tdo_o <= irs_q[0];
            end else if (use_bsr) begin
                tdo_o <= bsr_q[0];
            end else begin
                tdo_o <= byp_q;
            end
        end
    end

    assign pin_out = is_ext ? upd_q[2*NPIN-1:NPIN] : core_out;
    assign pin_oe = is_ext ? upd_q[CELLS-1:2*NPIN] : core_oe;
    assign core_in = is_ext ? upd_q[NPIN-1:0] : pin_in;
endmodule // bstp_port

/* bench/bstp_port_properties.sv */
`timescale 1ns/10ps
module bstp_port_properties #(parameter NPIN = 91) (
    input wire sys_clk,
    input wire resetn,
    input wire tck,
    input wire tdo_o,
    input wire tdo_oe,
    input wire [NPIN-1:0] core_out,
    input wire [NPIN-1:0] core_oe,
    input wire [NPIN-1:0] pin_in,
    input wire [NPIN-1:0] pin_out,
    input wire [NPIN-1:0] pin_oe,
    input wire [NPIN-1:0] core_in
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_rst_tdo_idle: assert property ($rose(resetn) |-> !tdo_oe && tdo_o)
        else $error("tdo not idle after reset");
    chk_rst_pin_pass: assert property ($rose(resetn) |-> pin_out == core_out)
        else $error("pins not passing core after reset");
    chk_rst_in_pass: assert property ($rose(resetn) |-> core_in == pin_in)
        else $error("core_in not passing pins after reset");
    chk_tdo_quiet: assert property ($stable(tck) [*8] |-> $stable(tdo_o))
        else $error("tdo moved without tck");
    chk_oe_quiet: assert property ($stable(tck) [*8] |-> $stable(tdo_oe))
        else $error("tdo_oe moved without tck");
    chk_pin_quiet: assert property ($stable(tck) [*8] ##0 $stable(core_out) |-> $stable(pin_out))
        else $error("pin_out moved by itself");
    chk_pin_oe_quiet: assert property ($stable(tck) [*8] ##0 $stable(core_oe) |-> $stable(pin_oe))
        else $error("pin_oe moved by itself");
    chk_core_in_quiet: assert property ($stable(tck) [*8] ##0 $stable(pin_in) |-> $stable(core_in))
        else $error("core_in moved by itself");
endmodule // bstp_port_properties

/* bench/bstp_tester.sv */
`timescale 1ns/10ps
// Board tester: tck parked low between frames
module bstp_tester (
    input wire sys_clk,
    input wire tdo_o,
    output reg tck = 1'h0,
    output reg tms = 1'h1,
    output reg tdi = 1'h0,
    output reg tms_oe_n = 1'h0,
    output reg tdi_oe_n = 1'h1,
    output reg tck_oe_n = 1'h0
);
    // tms/tdi change only while tck low
    task step(input m, input d, output q);
        @(negedge sys_clk);
        tck = 1'h0;
        tms = m;
        tdi = d;
        tdi_oe_n = 1'h0;
        repeat (4) @(negedge sys_clk);
        tck = 1'h1;
        repeat (3) @(negedge sys_clk);
        q = tdo_o;
    endtask
    task scan(input ir, input integer n, input [273:0] din, output [273:0] dout);
        integer i;
        reg q;
        step(1'h0, 1'h0, q);
        step(1'h1, 1'h0, q);
        if (ir)
            step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
        step(1'h0, 1'h0, q);
        for (i = 0; i < n; i = i + 1)
            step(i == n - 1, din[i], dout[i]);
        step(1'h1, 1'h0, q);
        step(1'h0, 1'h0, q);
        tck = 1'h0;
        tdi_oe_n = 1'h1;
        tdi = ~tdi;
    endtask
    task reset_free;
        reg q;
        tms_oe_n = 1'h1;
        repeat (5) step(1'h0, 1'h0, q);
        tms_oe_n = 1'h0;
        step(1'h0, 1'h0, q);
        tck = 1'h0;
    endtask
endmodule // bstp_tester

/* bench/test_bstp_port.sv */
`timescale 1ns/10ps
`include "bstp_consts.vh"
module test_bstp_port;
    localparam NPIN = 91;
    localparam BL = 273;
    reg sys_clk = 1'h0;
    reg resetn = 1'h0;
    reg [NPIN-1:0] core_out = {13{7'h35}}, core_oe = {13{7'h4c}}, pin_in = {13{7'h19}};
    wire tck, tms, tdi, tms_oe_n, tdi_oe_n, tck_oe_n, tdo_o, tdo_oe;
    wire [NPIN-1:0] pin_out, pin_oe, core_in;
    reg [273:0] dout;
    reg [273:0] din = {1'h1, {13{7'h63}}, {13{7'h2a}}, {13{7'h55}}};
    integer failures = 0, num_checks = 0, cycles = 0, k;
    bstp_port #(.BSR_LEN(BL), .NPIN(NPIN)) bstp_port_inst (.sys_clk(sys_clk), .resetn(resetn),
        .tck(tck), .tms(tms), .tdi(tdi), .tms_oe_n(tms_oe_n), .tdi_oe_n(tdi_oe_n),
        .tck_oe_n(tck_oe_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_out(core_out),
        .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .core_in(core_in));
    bstp_tester bstp_tester_inst (.sys_clk(sys_clk), .tdo_o(tdo_o), .tck(tck), .tms(tms),
        .tdi(tdi), .tms_oe_n(tms_oe_n), .tdi_oe_n(tdi_oe_n), .tck_oe_n(tck_oe_n));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, runs need about 5100 cycles
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    task cmp(input [8*12:1] nm, input [272:0] e, input [272:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    endtask
    task ir(input [2:0] op);
        bstp_tester_inst.scan(1'h1, 3, {271'h0, op}, dout);
        cmp("ir_capture", 3'h1, dout[2:0]);
    endtask
    // Unknown code 3 must behave as bypass
    task t_bypass;
        for (k = 3; k < 8; k = k + 4) begin
            ir(k[2:0]);
            bstp_tester_inst.scan(1'h0, 2, 274'h1, dout);
            cmp("bypass", 2'h2, dout[1:0]);
            cmp("core_pass", core_out, pin_out);
            cmp("tdo_oe_idle", 1'h0, tdo_oe);
        end
        $display("bypass test done");
    endtask
    task t_sample;
        ir(`BSTP_OP_SAMPLE);
        bstp_tester_inst.scan(1'h0, BL, din, dout);
        cmp("capture", {core_oe, core_out, pin_in}, dout[272:0]);
        cmp("sample_pass", core_out, pin_out);
        ir(`BSTP_OP_EXTEST);
        cmp("ext_out", din[181:91], pin_out);
        cmp("ext_oe", din[272:182], pin_oe);
        cmp("ext_core_in", din[90:0], core_in);
        pin_in = ~pin_in;
        bstp_tester_inst.scan(1'h0, BL + 1, din, dout);
        cmp("ext_capture", pin_in, dout[90:0]);
        cmp("length", din[0], dout[BL]);
        $display("sample and extest test done");
    endtask
    task t_pullup;
        ir(`BSTP_OP_EXTEST);
        bstp_tester_inst.reset_free;
        cmp("reset_pass", core_out, pin_out);
        bstp_tester_inst.scan(1'h0, 2, 274'h0, dout);
        cmp("reset_bypass", 2'h0, dout[1:0]);
        $display("pull-up reset test done");
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        resetn = 1'h1;
        repeat (3) @(negedge sys_clk);
        t_bypass;
        t_sample;
        t_pullup;
        end_of_test;
    end
endmodule // test_bstp_port
bind bstp_port bstp_port_properties #(.NPIN(NPIN)) bstp_port_properties_inst (
    .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .core_in(core_in));
